/* File: include/term_decode_pkg.sv */
/*
 * Shared constants for the input terminal command decoder: assignment codes,
 * terminal indices, direction encodings, alarm codes and the alarm reset minimum width.
 * Assumes a single 100 MHz system clock.
 */
package term_decode_pkg;

    // Terminal map: seven multifunction inputs, then the two run terminals
    localparam int NUM_TERM       = 9;
    localparam int TERM_MI7       = 6;
    localparam int TERM_RUN_FWD   = 7;
    localparam int TERM_RUN_REV   = 8;

    // Assignment code layout
    localparam int          CODE_W        = 11;
    localparam logic [10:0] CODE_INV_OFS  = 11'h3e8;  // 1000 selects active-off
    localparam logic [10:0] CODE_DEFAULT  = 11'h064;  // No function

    // Function codes (active-on form)
    localparam logic [10:0] FN_COAST_STOP       = 11'h007;
    localparam logic [10:0] FN_ALARM_RESET      = 11'h008;
    localparam logic [10:0] FN_EXTERNAL_TRIP    = 11'h009;
    localparam logic [10:0] FN_PID_CANCEL       = 11'h014;
    localparam logic [10:0] FN_DIRECTION_INVERT = 11'h015;
    localparam logic [10:0] FN_UNIVERSAL_DI     = 11'h019;
    localparam logic [10:0] FN_FORCED_STOP      = 11'h01e;
    localparam logic [10:0] FN_PID_RESET        = 11'h021;
    localparam logic [10:0] FN_PID_HOLD         = 11'h022;
    localparam logic [10:0] FN_LOCAL_KEYPAD     = 11'h023;
    localparam logic [10:0] FN_MOTOR_SET3       = 11'h024;
    localparam logic [10:0] FN_MOTOR_SET4       = 11'h025;
    localparam logic [10:0] FN_CONDENSATION     = 11'h027;
    localparam logic [10:0] FN_PULSE_TRAIN_IN   = 11'h030;
    localparam logic [10:0] FN_PULSE_TRAIN_SIGN = 11'h031;
    localparam logic [10:0] FN_JOG_FORWARD      = 11'h034;
    localparam logic [10:0] FN_JOG_REVERSE      = 11'h035;
    localparam logic [10:0] FN_DROOP            = 11'h04c;
    localparam logic [10:0] FN_TIMER_CANCEL     = 11'h050;
    localparam logic [10:0] FN_TIMER_CLEAR      = 11'h051;
    localparam logic [10:0] FN_RUN_FORWARD      = 11'h062;
    localparam logic [10:0] FN_RUN_REVERSE      = 11'h063;
    localparam logic [10:0] FN_NO_FUNCTION      = 11'h064;

    // Process controller modes and direction settings
    localparam logic [1:0] PID_MODE_NORMAL  = 2'h1;
    localparam logic [1:0] PID_MODE_REVERSE = 2'h2;
    localparam logic       DIR_FORWARD      = 1'h0;

    // Alarm codes shown on the display
    localparam logic [3:0] ALARM_NONE          = 4'h0;
    localparam logic [3:0] ALARM_EXTERNAL_TRIP = 4'h1;
    localparam logic [3:0] ALARM_FORCED_STOP   = 4'h2;

    // Alarm reset minimum width: 10 ms at 100 MHz
    localparam int CLK_HZ            = 100_000_000;
    localparam int RESET_MIN_MS      = 10;
    localparam int RESET_MIN_CYCLES  = CLK_HZ / 1000 * RESET_MIN_MS;

endpackage : term_decode_pkg

/* File: include/term_sync_if.sv */
/*
 * Carrier between the decoder top and its pin synchroniser.
 * Assumes both ends share ref_clk.
 */
`timescale 1ns/1ns
interface term_sync_if;
    import term_decode_pkg::*;
    logic [NUM_TERM-1:0] raw;      // Asynchronous pin levels
    logic [NUM_TERM-1:0] level;    // Filtered synchronous levels

    modport sync (input raw, output level);
    modport user (output raw, input level);
endinterface : term_sync_if

/* File: logic/term_sync.sv */
/*
 * Three-stage synchroniser for the terminal pins. A level changes only when
 * the second and third stages agree.
 * Assumes pins are asynchronous to ref_clk.
 */
`timescale 1ns/1ns
module term_sync
    import term_decode_pkg::*;
(
    // Clock and control
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    // Pin side and synchronous side
    term_sync_if.sync port
);

    typedef struct packed {
        logic [NUM_TERM-1:0] s1;
        logic [NUM_TERM-1:0] s2;
        logic [NUM_TERM-1:0] s3;
        logic [NUM_TERM-1:0] level;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    // Shift chain; first stage feeds only the second
    always_comb
    begin
        next_state    = state;
        next_state.s1 = port.raw;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        for (int i = 0; i < NUM_TERM; i++)
        begin
            if (state.s2[i] == state.s3[i])
            begin
                next_state.level[i] = state.s3[i];
            end
        end
    end

    // Register the whole state
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state <= '0;
        end
        else if (clk_en)
        begin
            state <= next_state;
        end
    end

    assign port.level = state.level;

endmodule : term_sync

/* File: logic/term_decoder.sv */
/*
 * Input terminal command decoder for a motor drive: maps per-terminal
 * assignment codes plus synchronised pin levels onto internal commands,
 * and keeps the latched trip and alarm state.
 * Assumes codes come from configuration logic and stay stable in use.
 */
// Function
// - Terminals default to positive logic; alternate code gives inverted logic.
// - Code and code plus 1000 are one function, opposite polarity.
// - Integral hold freezes the controller integral term while asserted.
// - Codes 35, 36, 37 select keypad, motor set 3, motor set 4.
// - Pulse-train input only on input seven; sign on any other input.
// - Run forward and reverse codes accepted only on run terminals.
// - Code 100 means no function; terminal state ignored.
// - Functions lacking an inverted code reject active-off assignment.
// - External trip: code 9 trips when off, 1009 when on.
// - Coast stop cuts output at once, raising no alarm.
// - Reset on clears alarm output; release clears display and hold.
// - External trip cuts output, shows its alarm code, asserts alarm; code acts on it only in ALM_IDLE.
// - External trip is latched until an alarm reset.
// - PID cancel bypasses controller, manual reference used instead.
// - Without PID, invert applies only to analog sources of command 1.
// - Analog direction equals direction setting xor invert input.
// - PID mode 1 normal, mode 2 reverse; invert flips either.
// - With PID cancelled and no analog source, direction follows manual setting only.
// - Universal digital input is monitored only, no drive effect.
// - Forced stop off decelerates with its own time, then alarms.
// - PID reset clears integral and differential components.
// - Codes 76, 80, 81 select droop, timer cancel, timer clear.
`timescale 1ns/1ns
module term_decoder
    import term_decode_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          clk_en,
    // Terminal pins and their assignment codes
    input  wire logic [NUM_TERM-1:0]           term_pin,
    input  wire logic [NUM_TERM*CODE_W-1:0]    term_code,
    // Drive configuration and status
    input  wire logic                          dir_setting,
    input  wire logic [1:0]                    pid_mode,
    input  wire logic                          analog_ref_sel,
    input  wire logic                          motor_stopped,
    // Output stage and alarm
    output logic                               output_cut,
    output logic                               forced_decel,
    output logic                               general_alarm_out,
    output logic [3:0]                         alarm_code,
    // Process controller commands
    output logic                               pid_active,
    output logic                               pid_integral_hold,
    output logic                               pid_component_reset,
    output logic                               final_reverse,
    // Other decoded commands
    output logic                               local_keypad_select,
    output logic                               motor_set3_select,
    output logic                               motor_set4_select,
    output logic                               condensation_prevent,
    output logic                               pulse_train_in,
    output logic                               pulse_train_sign,
    output logic                               jog_forward,
    output logic                               jog_reverse,
    output logic                               droop_control,
    output logic                               logic_timer_cancel,
    output logic                               logic_timer_clear_all,
    output logic                               run_forward_cmd,
    output logic                               run_reverse_cmd,
    output logic [NUM_TERM-1:0]                universal_digital_in,
    output logic [NUM_TERM-1:0]                code_rejected
);

    // ************************************************************
    // Pin synchronisation
    // ************************************************************

    term_sync_if sync_bus ();
    assign sync_bus.raw = term_pin;

    // Three-stage filter so no raw pin reaches decoding
    term_sync u_sync
    (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .port    (sync_bus.sync)
    );

    // ************************************************************
    // Function decoding
    // ************************************************************

    typedef enum logic [2:0]
    {
        ALM_IDLE  = 3'h1,
        ALM_HELD  = 3'h2,
        ALM_CLEAR = 3'h4
    } alarm_fsm_t;

    typedef struct packed {
        logic [NUM_TERM-1:0] udi;
        logic                trip_latched;
        logic                fstop_latched;
        logic                alarm_out;
        logic [3:0]          code;
        alarm_fsm_t          fsm;
        logic [26:0]         cmds;
    } dec_state_t;

    // Command bits in the cmds vector
    localparam int C_COAST = 0;
    localparam int C_RESET = 1;
    localparam int C_TRIP  = 2;
    localparam int C_PIDC  = 3;
    localparam int C_INV   = 4;
    localparam int C_FSTOP = 5;
    localparam int C_PRST  = 6;
    localparam int C_HOLD  = 7;
    localparam int C_LOC   = 8;
    localparam int C_M3    = 9;
    localparam int C_M4    = 10;
    localparam int C_DWP   = 11;
    localparam int C_PIN   = 12;
    localparam int C_SIGN  = 13;
    localparam int C_FJOG  = 14;
    localparam int C_RJOG  = 15;
    localparam int C_DROOP = 16;
    localparam int C_CLC   = 17;
    localparam int C_CLTC  = 18;
    localparam int C_FWD   = 19;
    localparam int C_REV   = 20;

    dec_state_t            state;
    dec_state_t            next_state;
    logic [26:0]           cmd;
    logic [NUM_TERM-1:0]   udi;
    logic [NUM_TERM-1:0]   rejected;

    // Is a function allowed with active-off polarity
    function automatic logic has_inverse(input logic [10:0] fn);
        has_inverse = !(fn == FN_CONDENSATION || fn == FN_PULSE_TRAIN_IN
                        || fn == FN_JOG_FORWARD || fn == FN_JOG_REVERSE
                        || fn == FN_RUN_FORWARD || fn == FN_RUN_REVERSE
                        || fn == FN_NO_FUNCTION);
    endfunction : has_inverse

    // Map each terminal onto command bits; invalid assignments contribute nothing
    always_comb
    begin
        logic [10:0] c;
        logic [10:0] fn;
        logic        inv;
        logic        act;
        logic        ok;
        c        = '0;
        fn       = '0;
        inv      = 1'b0;
        act      = 1'b0;
        ok       = 1'b0;
        cmd      = '0;
        udi      = '0;
        rejected = '0;
        for (int t = 0; t < NUM_TERM; t++)
        begin
            c   = term_code[t*CODE_W +: CODE_W];
            inv = (c >= CODE_INV_OFS);
            fn  = inv ? c - CODE_INV_OFS : c;
            act = sync_bus.level[t] ^ inv;
            ok  = !inv || has_inverse(fn);
            // Pulse input only on input seven, sign anywhere else
            if (fn == FN_PULSE_TRAIN_IN && t != TERM_MI7)
            begin
                ok = 1'b0;
            end
            else if (fn == FN_PULSE_TRAIN_SIGN && t == TERM_MI7)
            begin
                ok = 1'b0;
            end
            else if ((fn == FN_RUN_FORWARD || fn == FN_RUN_REVERSE)
                     && t != TERM_RUN_FWD && t != TERM_RUN_REV)
            begin
                ok = 1'b0;
            end
            rejected[t] = !ok;
            if (ok)
            begin
                if (fn == FN_COAST_STOP)            cmd[C_COAST] |= act;
                else if (fn == FN_ALARM_RESET)      cmd[C_RESET] |= act;
                else if (fn == FN_EXTERNAL_TRIP)    cmd[C_TRIP]  |= !act;  // Trips when off by default
                else if (fn == FN_PID_CANCEL)       cmd[C_PIDC]  |= act;
                else if (fn == FN_DIRECTION_INVERT) cmd[C_INV]   |= act;
                else if (fn == FN_UNIVERSAL_DI)     udi[t]        = act;   // Monitor only
                else if (fn == FN_FORCED_STOP)      cmd[C_FSTOP] |= !act;  // Fail-safe: stop when off
                else if (fn == FN_PID_RESET)        cmd[C_PRST]  |= act;
                else if (fn == FN_PID_HOLD)         cmd[C_HOLD]  |= act;
                else if (fn == FN_LOCAL_KEYPAD)     cmd[C_LOC]   |= act;
                else if (fn == FN_MOTOR_SET3)       cmd[C_M3]    |= act;
                else if (fn == FN_MOTOR_SET4)       cmd[C_M4]    |= act;
                else if (fn == FN_CONDENSATION)     cmd[C_DWP]   |= act;
                else if (fn == FN_PULSE_TRAIN_IN)   cmd[C_PIN]   |= act;
                else if (fn == FN_PULSE_TRAIN_SIGN) cmd[C_SIGN]  |= act;
                else if (fn == FN_JOG_FORWARD)      cmd[C_FJOG]  |= act;
                else if (fn == FN_JOG_REVERSE)      cmd[C_RJOG]  |= act;
                else if (fn == FN_DROOP)            cmd[C_DROOP] |= act;
                else if (fn == FN_TIMER_CANCEL)     cmd[C_CLC]   |= act;
                else if (fn == FN_TIMER_CLEAR)      cmd[C_CLTC]  |= act;
                else if (fn == FN_RUN_FORWARD)      cmd[C_FWD]   |= act;
                else if (fn == FN_RUN_REVERSE)      cmd[C_REV]   |= act;
                // Code 100 and unknown codes fall through untouched
            end
        end
    end

    // ************************************************************
    // Alarm and trip state
    // ************************************************************

    // Trip latch and alarm hold; a trip beats a forced stop in the same cycle
    always_comb
    begin
        next_state      = state;
        next_state.cmds = cmd;
        next_state.udi  = udi;
        case (state.fsm)
            ALM_IDLE:
            begin
                if (cmd[C_TRIP])
                begin
                    next_state.trip_latched = 1'b1;
                    next_state.alarm_out    = 1'b1;
                    next_state.code         = ALARM_EXTERNAL_TRIP;
                    next_state.fsm          = ALM_HELD;
                end
                else if (cmd[C_FSTOP] && motor_stopped)
                begin
                    next_state.fstop_latched = 1'b1;
                    next_state.alarm_out     = 1'b1;
                    next_state.code          = ALARM_FORCED_STOP;
                    next_state.fsm           = ALM_HELD;
                end
            end
            ALM_HELD:
            begin
                // Reset on drops the alarm relay only
                if (cmd[C_RESET])
                begin
                    next_state.alarm_out = 1'b0;
                    next_state.fsm       = ALM_CLEAR;
                end
            end
            ALM_CLEAR:
            begin
                // Release clears display and hold; trip stays latched till now
                if (!cmd[C_RESET])
                begin
                    next_state.trip_latched  = 1'b0;
                    next_state.fstop_latched = 1'b0;
                    next_state.code          = ALARM_NONE;
                    next_state.fsm           = ALM_IDLE;
                end
            end
            default:
            begin
                next_state.fsm = ALM_IDLE;
            end
        endcase
    end

    // Register the decoder state
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state     <= '0;
            state.fsm <= ALM_IDLE;
        end
        else if (clk_en)
        begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Coast stop and trip cut output; forced stop ramps, so it does not cut
    assign output_cut           = state.cmds[C_COAST] | state.trip_latched;
    assign forced_decel         = state.cmds[C_FSTOP] & !state.fstop_latched;
    assign general_alarm_out    = state.alarm_out;
    assign alarm_code           = state.code;

    // Controller gating: cancel bypasses it; hold and reset pass through regardless of cancel
    assign pid_active           = !state.cmds[C_PIDC];
    assign pid_integral_hold    = state.cmds[C_HOLD];
    assign pid_component_reset  = state.cmds[C_PRST];

    // Direction: PID mode xor invert, manual analog xor invert, else setting
    assign final_reverse = pid_active
                         ? ((pid_mode == PID_MODE_REVERSE) ^ state.cmds[C_INV])
                         : (analog_ref_sel ? (dir_setting ^ state.cmds[C_INV])
                                           : (dir_setting != DIR_FORWARD));

    assign local_keypad_select   = state.cmds[C_LOC];
    assign motor_set3_select     = state.cmds[C_M3];
    assign motor_set4_select     = state.cmds[C_M4];
    assign condensation_prevent  = state.cmds[C_DWP];
    assign pulse_train_in        = state.cmds[C_PIN];
    assign pulse_train_sign      = state.cmds[C_SIGN];
    assign jog_forward           = state.cmds[C_FJOG];
    assign jog_reverse           = state.cmds[C_RJOG];
    assign droop_control         = state.cmds[C_DROOP];
    assign logic_timer_cancel    = state.cmds[C_CLC];
    assign logic_timer_clear_all = state.cmds[C_CLTC];
    assign run_forward_cmd       = state.cmds[C_FWD];
    assign run_reverse_cmd       = state.cmds[C_REV];
    assign universal_digital_in  = state.udi;
    assign code_rejected         = rejected;

    // ************************************************************
    // Checks
    // ************************************************************

    property p_trip_latch;
        @(posedge ref_clk) disable iff (sys_rst)
        clk_en && state.fsm == ALM_IDLE && cmd[C_TRIP] |=> state.trip_latched && general_alarm_out
                                                        && alarm_code == ALARM_EXTERNAL_TRIP;
    endproperty
    a_trip_latch: assert property (p_trip_latch) else $error("trip not latched");

    property p_trip_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        state.trip_latched && state.fsm == ALM_HELD && !cmd[C_RESET] |=> state.trip_latched;
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("trip lost without reset");

    property p_reset_on;
        @(posedge ref_clk) disable iff (sys_rst)
        clk_en && state.fsm == ALM_HELD && cmd[C_RESET] |=> !general_alarm_out && alarm_code != ALARM_NONE;
    endproperty
    a_reset_on: assert property (p_reset_on) else $error("reset on mishandled");

    property p_coast;
        @(posedge ref_clk) disable iff (sys_rst)
        state.cmds[C_COAST] && !state.trip_latched |-> output_cut && !general_alarm_out;
    endproperty
    a_coast: assert property (p_coast) else $error("coast stop wrong");

    property p_direction;
        @(posedge ref_clk) disable iff (sys_rst)
        !pid_active && !analog_ref_sel |-> final_reverse == dir_setting;
    endproperty
    a_direction: assert property (p_direction) else $error("manual direction wrong");

    property p_pid_dir;
        @(posedge ref_clk) disable iff (sys_rst)
        pid_active && pid_mode == PID_MODE_NORMAL |-> final_reverse == state.cmds[C_INV];
    endproperty
    a_pid_dir: assert property (p_pid_dir) else $error("pid direction wrong");

    // A filtered level may only take the pin value seen four enabled edges earlier
    property p_sync_delay;
        @(posedge ref_clk) disable iff (sys_rst)
        clk_en && $past(clk_en) && $past(clk_en, 2) && $past(clk_en, 3) && $past(clk_en, 4)
        |-> ((sync_bus.level ^ $past(sync_bus.level)) & (sync_bus.level ^ $past(term_pin, 4))) == '0;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync path broken");

    property p_fstop_alarm;
        @(posedge ref_clk) disable iff (sys_rst)
        clk_en && state.fsm == ALM_IDLE && !cmd[C_TRIP] && cmd[C_FSTOP] && motor_stopped
        |=> alarm_code == ALARM_FORCED_STOP;
    endproperty
    a_fstop_alarm: assert property (p_fstop_alarm) else $error("forced stop alarm missing");

    c_trip:  cover property (@(posedge ref_clk) state.trip_latched);
    c_reset: cover property (@(posedge ref_clk) state.fsm == ALM_CLEAR ##1 state.fsm == ALM_IDLE);
    c_fstop: cover property (@(posedge ref_clk) alarm_code == ALARM_FORCED_STOP);

endmodule : term_decoder

/* File: tb/term_switches.sv */
/* Model of the external switches wired to the terminals.
   Assumes the bench asks for new contact states at the rising edge. */
`timescale 1ns/1ns
module term_switches
(
    // Clock and wanted contact states
    input  wire logic       ref_clk,
    input  wire logic [8:0] want,
    // Terminal levels
    output logic      [8:0] term_pin
);
    // Contacts close late, so pins are never aligned to the edge
    always @(posedge ref_clk)
        term_pin <= #3 want;
endmodule : term_switches

/* File: tb/test_term_decoder.sv */
/* Bench for the terminal decoder: codes and contacts in, commands checked.
   Assumes every answer lands within eight clocks of a contact change. */
`timescale 1ns/1ns
module test_term_decoder;
    import term_decode_pkg::*;
    // ****************
    // Bench signals
    // ****************
    logic             ref_clk = 0, sys_rst = 1, dir_setting = 0, motor_stopped = 0, asel = 1;
    logic [1:0]       pid_mode = 2'h1;
    logic [8:0]       want = 0, term_pin, ud, rej;
    logic [8:0][10:0] code = '0;
    logic             cut, fdec, alm, hold, kp, m3, m4, drp, tcn, tcl, pact, rev, pin, fwd, cnd;
    logic [3:0]       acode;
    int               error_cnt = 0, n_tests = 0;
    always #5 ref_clk = ~ref_clk;
    term_switches term_switches_i (.ref_clk(ref_clk), .want(want), .term_pin(term_pin));
    term_decoder term_decoder_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .term_pin(term_pin),
        .term_code(code), .dir_setting(dir_setting), .pid_mode(pid_mode), .analog_ref_sel(asel),
        .motor_stopped(motor_stopped), .output_cut(cut), .forced_decel(fdec), .general_alarm_out(alm),
        .alarm_code(acode), .pid_active(pact), .pid_integral_hold(hold), .pid_component_reset(),
        .final_reverse(rev), .local_keypad_select(kp), .motor_set3_select(m3), .motor_set4_select(m4),
        .condensation_prevent(cnd), .pulse_train_in(pin), .pulse_train_sign(), .jog_forward(),
        .jog_reverse(), .droop_control(drp), .logic_timer_cancel(tcn), .logic_timer_clear_all(tcl),
        .run_forward_cmd(fwd), .run_reverse_cmd(), .universal_digital_in(ud), .code_rejected(rej));
    // Compare and count
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Apply codes and contacts, then let the pipeline settle
    task automatic go(input logic [8:0][10:0] c, input logic [8:0] w);
        @(posedge ref_clk);
        code <= c;
        want <= w;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask : go
    task automatic test_done;
        if (error_cnt == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // Hang guard, far beyond the 140 or so clocks the tests need
    initial
    begin
        #100000;
        error_cnt++;
        test_done();
    end
    initial
    begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 0;
        go({{2{11'h064}}, 11'h051, 11'h050, 11'h04c, 11'h025, 11'h024, 11'h023, 11'h022}, 9'h07f);
        check("cmds", {hold, kp, m3, m4, drp, tcn, tcl}, 9'h07f);
        go(code, 9'h000);
        check("cmds off", {hold, kp, m3, m4, drp, tcn, tcl}, 9'h000);
        go({{8{11'h064}}, 11'h40a}, 9'h000);
        check("hold inv", hold, 9'h001);
        go({11'h40f, 11'h062, 11'h030, {4{11'h064}}, 11'h062, 11'h030}, 9'h1ff);
        check("rejected", rej, 9'h103);
        check("pulse run cond", {pin, fwd, cnd}, 9'h006);
        go({{6{11'h064}}, 11'h007, 11'h008, 11'h009}, 9'h001);
        check("idle", {cut, alm, acode}, 9'h000);
        go(code, 9'h000);
        check("trip", {cut, alm, acode}, 9'h031);
        go(code, 9'h001);
        check("trip held", {cut, alm, acode}, 9'h031);
        go(code, 9'h003);
        check("reset on", {cut, alm, acode}, 9'h021);
        go(code, 9'h001);
        check("reset off", {cut, alm, acode}, 9'h000);
        go(code, 9'h005);
        check("coast", {cut, alm, acode}, 9'h020);
        pid_mode <= 2'h2;
        go({{4{11'h064}}, 11'h01e, 11'h019, 11'h064, 11'h015, 11'h014}, 9'h008);
        check("pid rev", {pact, rev, fdec}, 9'h007);
        check("udi", ud, 9'h008);
        go(code, 9'h00a);
        check("pid inv", {pact, rev}, 9'h002);
        dir_setting <= 1;
        go(code, 9'h013);
        check("analog inv", {pact, rev}, 9'h000);
        asel <= 0;
        go(code, 9'h013);
        check("manual", {pact, rev}, 9'h001);
        motor_stopped <= 1;
        go(code, 9'h003);
        check("stop alarm", acode, 9'h002);
        test_done();
    end
endmodule : test_term_decoder
